// File: hw/dmbc_pkg.sv
// Purpose: shared constants of the dc motor bridge controller
// Assumes: 125 MHz system clock, register map on avalon-mm with byte addresses
// Notes: settings are 16-bit words, one per aligned 32-bit slot
package dmbc_pkg;
  // clock and time base
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_US = 100;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TICKS_PER_MS = 1000 / TICK_US;
  localparam int TICKS_PER_10MS = 10 * TICKS_PER_MS;
  localparam int SEC_TICKS = 1000 * TICKS_PER_MS;
  localparam int HOUR_SECS = 3600;
  localparam int LED_STEP_TICKS = 100 * TICKS_PER_MS;
  // pwm: 100 duty steps per period, prescale = clock / (frequency * steps)
  localparam int PWM_STEPS = 100;
  localparam int PWM_LOW_HZ = 2000;
  localparam int PWM_HIGH_HZ = 16000;
  localparam int PWM_PRE_LOW = CLK_HZ / (PWM_LOW_HZ * PWM_STEPS);
  localparam int PWM_PRE_HIGH = CLK_HZ / (PWM_HIGH_HZ * PWM_STEPS);
  localparam int PWM_SEL_HIGH = 2;
  // supply voltage in 0.1 V units, limits in volts
  localparam int VOLT_SCALE = 10;
  localparam int OV2_SCALE = 11;
  localparam int FULL_DUTY = 100;
  // setting indexes, byte address is four times the index
  localparam int NCFG = 21;
  localparam int CFG_MODE = 0, CFG_STARTC = 1, CFG_INLOGIC = 2, CFG_SPEED1 = 3, CFG_SPEED2 = 4;
  localparam int CFG_ILIMF = 5, CFG_ILIMR = 6, CFG_TRIP = 7, CFG_TRIPDLY = 8, CFG_FAULTSEL = 9;
  localparam int CFG_OVLIM = 10, CFG_TIMEOUT = 11, CFG_CNTRST = 12, CFG_RAMPUP = 13, CFG_RAMPDN = 14;
  localparam int CFG_KICK = 15, CFG_AUTOREV = 16, CFG_FREEWHEEL = 17, CFG_PWMFREQ = 18;
  localparam int CFG_BRAKELIM = 19, CFG_BRAKEOPT = 20;
  localparam logic [15:0] CFG_RST [NCFG] = '{16'h0000, 16'h0001, 16'h0000, 16'h0064, 16'h0032,
    16'h001e, 16'h001e, 16'h0001, 16'h0014, 16'h0001, 16'h003c, 16'h0000, 16'h0000, 16'h0064,
    16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0032, 16'h0000};
  // other byte offsets
  localparam logic [7:0] ADDR_SAVE = 8'h60;
  localparam logic [7:0] ADDR_CUR = 8'h80, ADDR_DUTY = 8'h84, ADDR_HOURS = 8'h88, ADDR_STARTS = 8'h8c;
  localparam logic [7:0] ADDR_CARRY = 8'h90, ADDR_BRKCUR = 8'h94, ADDR_FLAGS = 8'h98;
  // fault led patterns, msb first, one bit per 100 ms
  localparam logic [15:0] LED_POWERUP = 16'hc000, LED_LIMIT = 16'hffff, LED_OCTRIP = 16'haaaa;
  localparam logic [15:0] LED_ZCTRIP = 16'hfffc, LED_OV = 16'haa00, LED_HEAT = 16'h8000;
  localparam logic [15:0] LED_TOUT = 16'habc0, LED_FIN = 16'haf00;
  // motor sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN = 4'b0010,
    ST_STOP = 4'b0100,
    ST_AREV = 4'b1000
  } dmbc_state_t;
endpackage : dmbc_pkg

// File: hw/dmbc_top.sv
// Purpose: control logic of a full-bridge brushed dc motor starter
// Assumes: adc words arrive on sys_clk; pins are asynchronous and synchronised here
// Notes: settings and monitor values sit behind an avalon-mm slave
//
// Notes on behaviour
// - command mode: 0 continuous, 1 impulse
// - continuous runs while held; impulse toggles on pulse
// - start condition restricts direction after trip/stop
// - selectable polarity for command and limit inputs
// - two preset speeds, defaults 100 and 50
// - speed-2 setting 0 makes input analog
// - speed-2 setting 1: analog, autorun, reverse input
// - per-direction current limits; both zero uses input
// - trip setting enables overcurrent and zero-current trips
// - overcurrent must persist trip delay milliseconds
// - fault output condition selected by setting
// - external low fault line stops, blocks starts
// - freewheel options on overvoltage, stop, stop ramp
// - pwm frequency 2 kHz or 16 kHz
// - braking current limit while regenerating
// - brake load on overvoltage, running, or stop
// - overvoltage: brake load, then freewheel at +10%
// - run timeout 0-255 s, zero disables
// - report current, pwm, hours, starts, carry, brake
// - counter reset setting plus save clears counters
// - start and stop ramps coded 0-500
// - start kick gives full drive for milliseconds
// - auto-reverse after overcurrent trip for set time
// - fault led blink codes per condition
//
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module dmbc_top #(
  parameter int TICK_CYC = dmbc_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  // operator pins, asynchronous
  input wire logic forwardCommand,
  input wire logic backwardCommand,
  input wire logic stopCommand,
  input wire logic limitFwd,
  input wire logic limitRev,
  input wire logic speed2Sel,
  input wire logic overheat,
  // shared open-drain fault line
  input wire logic faultIn,
  output logic faultOut,
  output logic faultOeN,
  // measurements from adc logic, same clock
  input wire logic [7:0] motorCurrent,
  input wire logic [7:0] brakeCurrent,
  input wire logic [9:0] supplyVolt,
  input wire logic [6:0] speedIn,
  input wire logic [7:0] ilimIn,
  // power stage and indicators
  output logic bridgeFwd,
  output logic bridgeRev,
  output logic freewheel,
  output logic brakeLoad,
  output logic faultLed
);
  typedef struct packed {
    logic waitQ;
    logic [31:0] rdData;
    logic [dmbc_pkg::NCFG-1:0][15:0] cfg;
    logic [7:0] sy1;
    logic [7:0] sy2;
    logic [1:0] prevCmd;
    dmbc_pkg::dmbc_state_t state;
    logic dir;
    logic impRun;
    logic impDir;
    logic latchOff;
    logic blockF;
    logic blockR;
    logic tripOc;
    logic tripZc;
    logic toutF;
    logic powerUp;
    logic [6:0] duty;
    logic [13:0] tickCnt;
    logic [9:0] rampCnt;
    logic [9:0] pwmPre;
    logic [6:0] pwmCnt;
    logic [15:0] tmr;
    logic [11:0] ocCnt;
    logic [11:0] zcCnt;
    logic [13:0] secCnt;
    logic [7:0] runSec;
    logic [11:0] hourSec;
    logic [15:0] hours;
    logic [15:0] starts;
    logic [15:0] carry;
    logic [3:0] ledSlot;
    logic [9:0] ledPre;
    logic [1:0] relCnt;
    logic bFwd;
    logic bRev;
    logic fwOut;
    logic brkOut;
    logic oeN;
    logic ledOut;
  } dmbc_reg_t;

  dmbc_reg_t q;
  dmbc_reg_t d;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic tick, cmdLow, limLow, limNc, fwdIn, bwdIn, stopIn, limF, limR, spd2, extFault, hot;
    logic alt, analog, wantRun, wantDir, stopAll, blocked, overCur, limiting, ov, ov2;
    logic rampStep, running, pwmOn, kicking, saveHit, faultPull;
    logic [7:0] lim, idx;
    logic [6:0] target;
    logic [9:0] rampCode, pwmPreMax;
    logic [11:0] dlyTicks;
    logic [15:0] pat;
    tick = 1'b0; cmdLow = 1'b0; limLow = 1'b0; limNc = 1'b0; fwdIn = 1'b0; bwdIn = 1'b0;
    stopIn = 1'b0; limF = 1'b0; limR = 1'b0; spd2 = 1'b0; extFault = 1'b0; hot = 1'b0;
    alt = 1'b0; analog = 1'b0; wantRun = 1'b0; wantDir = 1'b0; stopAll = 1'b0; blocked = 1'b0;
    overCur = 1'b0; limiting = 1'b0; ov = 1'b0; ov2 = 1'b0; rampStep = 1'b0; running = 1'b0;
    pwmOn = 1'b0; kicking = 1'b0; saveHit = 1'b0; faultPull = 1'b0;
    lim = 8'h00; idx = 8'h00; target = 7'h00; rampCode = 10'h000; pwmPreMax = 10'h000;
    dlyTicks = 12'h000; pat = 16'h0000;
    d = q;

    // pin synchronisers: first stage feeds only the second
    d.sy1 = {faultIn, overheat, speed2Sel, limitRev, limitFwd, stopCommand, backwardCommand, forwardCommand};
    d.sy2 = q.sy1;

    // 100 us time base
    tick = (q.tickCnt == 14'(TICK_CYC - 1));
    d.tickCnt = tick ? 14'h0000 : q.tickCnt + 14'h0001;

    // input polarity: bit0 command low-active, bit1 limits low-active, bit2 limits normally closed
    cmdLow = q.cfg[dmbc_pkg::CFG_INLOGIC][0];
    limLow = q.cfg[dmbc_pkg::CFG_INLOGIC][1];
    limNc = q.cfg[dmbc_pkg::CFG_INLOGIC][2];
    fwdIn = q.sy2[0] ^ cmdLow;
    bwdIn = q.sy2[1] ^ cmdLow;
    stopIn = q.sy2[2] ^ cmdLow;
    limF = q.sy2[3] ^ limLow ^ limNc;
    limR = q.sy2[4] ^ limLow ^ limNc;
    spd2 = q.sy2[5] ^ cmdLow;
    hot = q.sy2[6];

    // ignore our own pull until the released line has passed the synchroniser
    d.relCnt = q.oeN ? ((q.relCnt == 2'h3) ? 2'h3 : q.relCnt + 2'h1) : 2'h0;
    extFault = ~q.sy2[7] & (q.relCnt == 2'h3);

    // command interpretation
    alt = (q.cfg[dmbc_pkg::CFG_SPEED2] == 16'h0001);
    analog = alt | (q.cfg[dmbc_pkg::CFG_SPEED2] == 16'h0000);
    d.prevCmd = {bwdIn, fwdIn};
    if ((fwdIn & ~q.prevCmd[0]) | (bwdIn & ~q.prevCmd[1])) begin
      d.impRun = ~q.impRun;
      d.impDir = bwdIn & ~q.prevCmd[1];
    end
    if (alt) begin
      wantRun = 1'b1;
      wantDir = bwdIn;
    end else if (q.cfg[dmbc_pkg::CFG_MODE][0]) begin
      wantRun = q.impRun;
      wantDir = q.impDir;
    end else begin
      wantRun = fwdIn | bwdIn;
      wantDir = ~fwdIn;
      d.impRun = 1'b0;
    end
    stopAll = stopIn | extFault | hot | (q.dir ? limR : limF);
    blocked = wantDir ? (q.blockR | limR) : (q.blockF | limF);
    if (~wantRun) begin
      d.latchOff = 1'b0; // a fresh command is needed after a fault, overheat, trip or timeout stop in ST_RUN
    end

    // speed target
    if (analog) begin
      target = (speedIn > 7'(dmbc_pkg::FULL_DUTY)) ? 7'(dmbc_pkg::FULL_DUTY) : speedIn;
    end else begin
      target = spd2 ? q.cfg[dmbc_pkg::CFG_SPEED2][6:0] : q.cfg[dmbc_pkg::CFG_SPEED1][6:0];
    end

    // current supervision
    if (q.cfg[dmbc_pkg::CFG_ILIMF] == 16'h0000 && q.cfg[dmbc_pkg::CFG_ILIMR] == 16'h0000) begin
      lim = ilimIn;
    end else begin
      lim = q.dir ? q.cfg[dmbc_pkg::CFG_ILIMR][7:0] : q.cfg[dmbc_pkg::CFG_ILIMF][7:0];
    end
    overCur = (motorCurrent > lim);
    running = (q.state == dmbc_pkg::ST_RUN) | (q.state == dmbc_pkg::ST_AREV);
    limiting = running & overCur;
    dlyTicks = 12'(q.cfg[dmbc_pkg::CFG_TRIPDLY][7:0] * dmbc_pkg::TICKS_PER_MS);
    if (tick) begin
      d.ocCnt = (running & overCur) ? ((q.ocCnt == 12'hfff) ? q.ocCnt : q.ocCnt + 12'h001) : 12'h000;
      d.zcCnt = (running & (motorCurrent == 8'h00) & (q.duty != 7'h00))
        ? ((q.zcCnt == 12'hfff) ? q.zcCnt : q.zcCnt + 12'h001) : 12'h000;
    end

    // supply supervision, volts scaled to 0.1 V units
    ov = supplyVolt > 10'(q.cfg[dmbc_pkg::CFG_OVLIM][7:0] * dmbc_pkg::VOLT_SCALE);
    ov2 = supplyVolt > 10'(q.cfg[dmbc_pkg::CFG_OVLIM][7:0] * dmbc_pkg::OV2_SCALE);

    // ramp step: one duty percent every setting-count plus one ticks, so full swing takes (count + 1) x 10 ms
    rampCode = (q.state == dmbc_pkg::ST_STOP) ? q.cfg[dmbc_pkg::CFG_RAMPDN][9:0] : q.cfg[dmbc_pkg::CFG_RAMPUP][9:0];
    if (tick) begin
      rampStep = (q.rampCnt >= rampCode);
      d.rampCnt = rampStep ? 10'h000 : q.rampCnt + 10'h001;
    end

    // run timeout and usage counters
    if (running & tick) begin
      d.secCnt = (q.secCnt == 14'(dmbc_pkg::SEC_TICKS - 1)) ? 14'h0000 : q.secCnt + 14'h0001;
      if (q.secCnt == 14'(dmbc_pkg::SEC_TICKS - 1)) begin
        d.runSec = (q.runSec == 8'hff) ? q.runSec : q.runSec + 8'h01;
        d.hourSec = (q.hourSec == 12'(dmbc_pkg::HOUR_SECS - 1)) ? 12'h000 : q.hourSec + 12'h001;
        if (q.hourSec == 12'(dmbc_pkg::HOUR_SECS - 1) && q.hours != 16'hffff) begin
          d.hours = q.hours + 16'h0001;
        end
      end
    end
    if (q.tmr != 16'h0000 && tick) begin
      d.tmr = q.tmr - 16'h0001;
    end
    kicking = (q.state == dmbc_pkg::ST_RUN) & (q.tmr != 16'h0000);

    // motor sequencer
    case (q.state)
      dmbc_pkg::ST_IDLE: begin
        d.duty = 7'h00;
        if (wantRun & ~stopAll & ~q.latchOff & ~blocked) begin
          d.state = dmbc_pkg::ST_RUN;
          d.dir = wantDir;
          d.tmr = 16'(q.cfg[dmbc_pkg::CFG_KICK][7:0] * dmbc_pkg::TICKS_PER_MS);
          d.runSec = 8'h00;
          d.secCnt = 14'h0000;
          d.blockF = 1'b0;
          d.blockR = 1'b0;
          d.tripOc = 1'b0;
          d.tripZc = 1'b0;
          d.toutF = 1'b0;
          d.starts = q.starts + 16'h0001;
          if (q.starts == 16'hffff) begin
            d.carry = q.carry + 16'h0001;
          end
        end
      end
      dmbc_pkg::ST_RUN: begin
        if (rampStep) begin
          if (limiting && q.duty != 7'h00) begin
            d.duty = q.duty - 7'h01;
          end else if (q.duty < target) begin
            d.duty = q.duty + 7'h01;
          end else if (q.duty > target) begin
            d.duty = q.duty - 7'h01;
          end
        end
        if (extFault | hot) begin
          d.state = dmbc_pkg::ST_IDLE;
          d.latchOff = 1'b1;
          d.impRun = 1'b0;
        end else if (q.cfg[dmbc_pkg::CFG_TRIP][0] && q.ocCnt >= dlyTicks && overCur) begin
          d.tripOc = 1'b1;
          d.latchOff = 1'b1;
          d.impRun = 1'b0;
          d.duty = 7'h00;
          d.blockF = q.cfg[dmbc_pkg::CFG_STARTC][0] & ~q.dir;
          d.blockR = q.cfg[dmbc_pkg::CFG_STARTC][0] & q.dir;
          if (q.cfg[dmbc_pkg::CFG_AUTOREV] != 16'h0000) begin
            d.state = dmbc_pkg::ST_AREV;
            d.dir = ~q.dir;
            d.tmr = 16'(q.cfg[dmbc_pkg::CFG_AUTOREV][9:0] * dmbc_pkg::TICKS_PER_10MS);
          end else begin
            d.state = dmbc_pkg::ST_IDLE;
          end
        end else if (q.cfg[dmbc_pkg::CFG_TRIP][1] && q.zcCnt >= dlyTicks && q.zcCnt != 12'h000) begin
          d.tripZc = 1'b1;
          d.state = dmbc_pkg::ST_IDLE;
          d.latchOff = 1'b1;
          d.impRun = 1'b0;
        end else if (q.cfg[dmbc_pkg::CFG_TIMEOUT] != 16'h0000 &&
                     q.runSec >= q.cfg[dmbc_pkg::CFG_TIMEOUT][7:0]) begin
          d.toutF = 1'b1;
          d.state = dmbc_pkg::ST_STOP;
          d.latchOff = 1'b1;
          d.impRun = 1'b0;
        end else if (~wantRun | (wantDir != q.dir) | stopAll) begin
          d.state = dmbc_pkg::ST_STOP;
          d.blockF = q.cfg[dmbc_pkg::CFG_STARTC][1] & ~q.dir;
          d.blockR = q.cfg[dmbc_pkg::CFG_STARTC][1] & q.dir;
          if (stopIn) begin
            d.impRun = 1'b0;
          end
        end
      end
      dmbc_pkg::ST_STOP: begin
        if (extFault | hot | (q.duty == 7'h00)) begin
          d.state = dmbc_pkg::ST_IDLE;
          d.duty = 7'h00;
        end else if (rampStep && brakeCurrent <= q.cfg[dmbc_pkg::CFG_BRAKELIM][7:0]) begin
          d.duty = q.duty - 7'h01;
        end
      end
      dmbc_pkg::ST_AREV: begin
        d.duty = target;
        if (q.tmr == 16'h0000 || extFault || hot) begin
          d.state = dmbc_pkg::ST_IDLE;
          d.duty = 7'h00;
        end
      end
      default: begin
        d.state = dmbc_pkg::ST_IDLE;
        d.duty = 7'h00;
      end
    endcase

    // pwm carrier: 100 steps per period
    pwmPreMax = (q.cfg[dmbc_pkg::CFG_PWMFREQ] == 16'(dmbc_pkg::PWM_SEL_HIGH))
      ? 10'(dmbc_pkg::PWM_PRE_HIGH - 1) : 10'(dmbc_pkg::PWM_PRE_LOW - 1);
    d.pwmPre = (q.pwmPre >= pwmPreMax) ? 10'h000 : q.pwmPre + 10'h001;
    if (q.pwmPre >= pwmPreMax) begin
      d.pwmCnt = (q.pwmCnt == 7'(dmbc_pkg::PWM_STEPS - 1)) ? 7'h00 : q.pwmCnt + 7'h01;
    end
    pwmOn = kicking | (q.pwmCnt < q.duty);

    // freewheel: second overvoltage level always, the rest per option
    case (q.cfg[dmbc_pkg::CFG_FREEWHEEL][2:0])
      3'h0: d.fwOut = ov2;
      3'h1: d.fwOut = ov2 | (q.state == dmbc_pkg::ST_IDLE);
      3'h2: d.fwOut = ov2 | (q.state == dmbc_pkg::ST_STOP);
      3'h3: d.fwOut = ov2 | (q.state == dmbc_pkg::ST_IDLE) | (q.state == dmbc_pkg::ST_STOP);
      3'h4: d.fwOut = ov2 | (q.state == dmbc_pkg::ST_IDLE);
      default: d.fwOut = ov2;
    endcase
    d.bFwd = running & ~q.dir & pwmOn & ~ov2 | (q.state == dmbc_pkg::ST_STOP) & ~q.dir & pwmOn & ~d.fwOut;
    d.bRev = running & q.dir & pwmOn & ~ov2 | (q.state == dmbc_pkg::ST_STOP) & q.dir & pwmOn & ~d.fwOut;

    // brake load output
    case (q.cfg[dmbc_pkg::CFG_BRAKEOPT][1:0])
      2'h1: d.brkOut = running;
      2'h2: d.brkOut = running | stopIn;
      default: d.brkOut = ov;
    endcase

    // fault line pull-down, overheat always pulls
    case (q.cfg[dmbc_pkg::CFG_FAULTSEL][2:0])
      3'h0: faultPull = 1'b0;
      3'h1: faultPull = q.tripOc;
      3'h2: faultPull = q.tripZc;
      3'h3: faultPull = q.tripOc | q.tripZc;
      3'h4: faultPull = limiting;
      3'h5: faultPull = running;
      default: faultPull = 1'b0;
    endcase
    d.oeN = ~(faultPull | hot);

    // fault led blink codes, highest priority first
    if (extFault) pat = dmbc_pkg::LED_FIN;
    else if (q.toutF) pat = dmbc_pkg::LED_TOUT;
    else if (hot) pat = dmbc_pkg::LED_HEAT;
    else if (ov) pat = dmbc_pkg::LED_OV;
    else if (q.tripZc) pat = dmbc_pkg::LED_ZCTRIP;
    else if (q.tripOc) pat = dmbc_pkg::LED_OCTRIP;
    else if (limiting) pat = dmbc_pkg::LED_LIMIT;
    else if (q.powerUp) pat = dmbc_pkg::LED_POWERUP;
    else pat = 16'h0000;
    if (tick) begin
      d.ledPre = (q.ledPre == 10'(dmbc_pkg::LED_STEP_TICKS - 1)) ? 10'h000 : q.ledPre + 10'h001;
      if (q.ledPre == 10'(dmbc_pkg::LED_STEP_TICKS - 1)) begin
        d.ledSlot = q.ledSlot + 4'h1;
        if (q.ledSlot == 4'hf) begin
          d.powerUp = 1'b0; // the power-up blink plays once
        end
      end
    end
    d.ledOut = pat[4'hf - q.ledSlot];

    // avalon slave: one wait cycle, action and read data on the accepting edge
    idx = {2'b00, avsAddress[7:2]};
    d.waitQ = ~((avsRead | avsWrite) & q.waitQ);
    if ((avsRead | avsWrite) & q.waitQ) begin
      d.rdData = 32'h0000_0000;
      if (idx < 8'(dmbc_pkg::NCFG)) begin
        d.rdData = {16'h0000, q.cfg[idx]};
        if (avsWrite & avsByteenable[0]) d.cfg[idx][7:0] = avsWritedata[7:0];
        if (avsWrite & avsByteenable[1]) d.cfg[idx][15:8] = avsWritedata[15:8];
      end else begin
        case (avsAddress)
          dmbc_pkg::ADDR_SAVE: saveHit = avsWrite;
          dmbc_pkg::ADDR_CUR: d.rdData = {24'h000000, motorCurrent};
          dmbc_pkg::ADDR_DUTY: d.rdData = {25'h0000000, q.duty};
          dmbc_pkg::ADDR_HOURS: d.rdData = {16'h0000, q.hours};
          dmbc_pkg::ADDR_STARTS: d.rdData = {16'h0000, q.starts};
          dmbc_pkg::ADDR_CARRY: d.rdData = {16'h0000, q.carry};
          dmbc_pkg::ADDR_BRKCUR: d.rdData = {24'h000000, brakeCurrent};
          dmbc_pkg::ADDR_FLAGS: d.rdData = {20'h00000, q.state, limiting, ov, q.toutF, q.tripZc,
                                            q.tripOc, extFault, q.dir, running};
          default: d.rdData = 32'h0000_0000;
        endcase
      end
    end
    if (saveHit && q.cfg[dmbc_pkg::CFG_CNTRST] == 16'h0001) begin
      d.hours = 16'h0000;
      d.starts = 16'h0000;
      d.carry = 16'h0000;
      d.hourSec = 12'h000;
      d.cfg[dmbc_pkg::CFG_CNTRST] = 16'h0000;
    end

    // synchronous reset
    if (sys_rst) begin
      d = '0;
      for (int i = 0; i < dmbc_pkg::NCFG; i++) begin
        d.cfg[i] = dmbc_pkg::CFG_RST[i];
      end
      d.state = dmbc_pkg::ST_IDLE;
      d.waitQ = 1'b1;
      d.oeN = 1'b1;
      d.powerUp = 1'b1;
      d.fwOut = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  // outputs straight from flops, fault data tied low
  assign avsReaddata = q.rdData;
  assign avsWaitrequest = q.waitQ;
  assign faultOut = 1'b0; // open drain: the line is only ever pulled low
  assign faultOeN = q.oeN;
  assign bridgeFwd = q.bFwd;
  assign bridgeRev = q.bRev;
  assign freewheel = q.fwOut;
  assign brakeLoad = q.brkOut;
  assign faultLed = q.ledOut;
endmodule : dmbc_top
`default_nettype wire

// File: verif/dmbc_monitor.sv
// Purpose: port-level assertions for the motor bridge controller
// Assumes: one sys_clk domain, synchronous active-high reset
// Notes: overvoltage figures use the top of the limit range (65 V)
`timescale 1ns/1ps
`default_nettype none
module dmbc_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register bus
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsReaddata,
  input wire logic avsWaitrequest,
  // supply, fault wire and power stage
  input wire logic [9:0] supplyVolt,
  input wire logic faultOut,
  input wire logic bridgeFwd,
  input wire logic bridgeRev,
  input wire logic freewheel,
  input wire logic brakeLoad
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // bus: exactly one wait cycle, answer stands one cycle, data held between accesses
  bus_answer_a: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("bus answer late");
  bus_stand_a: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("bus answer too long");
  read_hold_a: assert property (!avsRead && !avsWrite && avsWaitrequest |=> $stable(avsReaddata))
    else $error("read data moved");
  unmapped_zero_a: assert property (avsRead && avsWaitrequest && avsAddress >= 8'h9c |=> avsReaddata == 32'h0)
    else $error("unmapped read not zero");
  ////////////////////////////////////////////////////////////////////////////////
  // power stage: one direction at a time, freewheel means all switches off
  bridge_excl_a: assert property (!(bridgeFwd && bridgeRev))
    else $error("both directions driven");
  freewheel_off_a: assert property (freewheel |-> !bridgeFwd && !bridgeRev)
    else $error("drive during freewheel");
  // the fault wire is open drain: the data side never drives high
  fault_out_a: assert property (faultOut == 1'b0)
    else $error("fault data not low");
  // above any legal limit the brake load comes first, +10 percent frees the bridge
  ov_brake_a: assert property (supplyVolt > 10'd650 |-> ##[1:3] brakeLoad)
    else $error("brake load missing");
  ov_freewheel_a: assert property (supplyVolt > 10'd715 |-> ##[1:4] freewheel)
    else $error("freewheel missing");
endmodule : dmbc_monitor
`default_nettype wire

// File: verif/dmbc_bridge_model.sv
// Purpose: power bridge and shared fault wire seen from the controller
// Assumes: current follows the switches with no delay
// Notes: the wire has a pull-up, so released means high
`timescale 1ns/1ps
`default_nettype none
module dmbc_bridge_model (
  // drive from the controller
  input wire logic bridgeFwd,
  input wire logic bridgeRev,
  input wire logic faultOeN,
  // bench controls
  input wire logic [7:0] loadAmps,
  input wire logic extPull,
  // measured values and wire level
  output logic [7:0] motorCurrent,
  output logic faultIn
);
  // current only flows while a switch pair conducts
  assign motorCurrent = (bridgeFwd || bridgeRev) ? loadAmps : 8'h00;
  // open drain: low if any party pulls, pull-up otherwise
  assign faultIn = !(extPull || !faultOeN);
endmodule : dmbc_bridge_model
`default_nettype wire

// File: verif/dmbc_tb_top.sv
// Purpose: scenario bench for the motor bridge controller
// Assumes: short time base, ramps set to one step per tick
// Notes: scenarios share the bus and compare tasks
`timescale 1ns/1ps
`default_nettype none
module dmbc_tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avsAddress = 8'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata;
  logic avsWaitrequest, faultOut, faultOeN, faultIn, bridgeFwd, bridgeRev, freewheel, brakeLoad, faultLed;
  logic fwdCmd = 1'b0, bwdCmd = 1'b0, extPull = 1'b0;
  logic [7:0] loadAmps = 8'h0;
  logic [4:0] p = 5'h0;
  logic [7:0] motorCurrent;
  logic [9:0] supplyVolt = 10'h1e0;
  logic [31:0] v;
  int bad_count = 0;
  int samples_checked = 0;
  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;
  dmbc_top #(.TICK_CYC(10)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(4'hf),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .forwardCommand(fwdCmd),
    .backwardCommand(bwdCmd), .stopCommand(p[0]), .limitFwd(p[1]), .limitRev(p[2]), .speed2Sel(p[3]),
    .overheat(p[4]), .faultIn(faultIn), .faultOut(faultOut), .faultOeN(faultOeN),
    .motorCurrent(motorCurrent), .brakeCurrent(8'h00), .supplyVolt(supplyVolt), .speedIn(7'h00),
    .ilimIn(8'h00), .bridgeFwd(bridgeFwd), .bridgeRev(bridgeRev), .freewheel(freewheel),
    .brakeLoad(brakeLoad), .faultLed(faultLed));
  dmbc_bridge_model u_bridge (.bridgeFwd(bridgeFwd), .bridgeRev(bridgeRev), .faultOeN(faultOeN),
    .loadAmps(loadAmps), .extPull(extPull), .motorCurrent(motorCurrent), .faultIn(faultIn));
  ////////////////////////////////////////////////////////////////////////////////
  // bus master: request held until waitrequest is sampled low
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    avsAddress <= a; avsWritedata <= d; avsWrite <= 1'b1;
    do @(posedge sys_clk); while (avsWaitrequest !== 1'b0);
    avsWrite <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    avsAddress <= a; avsRead <= 1'b1;
    do @(posedge sys_clk); while (avsWaitrequest !== 1'b0);
    v = avsReaddata;
    avsRead <= 1'b0;
    @(posedge sys_clk);
  endtask : rd
  task automatic cmp(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic waitc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : waitc
  task end_of_test;
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  // defaults, write with dead upper lanes, unmapped read
  task t_regs;
    logic [7:0] ad [6];
    logic [15:0] ex [6];
    ad = '{8'h00, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20};
    ex = '{16'h0, 16'h64, 16'h32, 16'h1e, 16'h1, 16'h14};
    for (int i = 0; i < 6; i++) begin
      rd(ad[i]);
      cmp("setting", {16'h0, ex[i]}, v);
    end
    cmp("led", 1, faultLed);
    wr(8'h0c, 32'hffff0042);
    rd(8'h0c);
    cmp("speed1", 32'h42, v);
    wr(8'h0c, 32'h64);
    rd(8'h9c);
    cmp("unmapped", 32'h0, v);
  endtask : t_regs
  // continuous run with ramp, stops on release
  task t_run;
    wr(8'h34, 32'h0); wr(8'h38, 32'h0); wr(8'h48, 32'h2);
    fwdCmd <= 1'b1;
    waitc(300); rd(8'h84);
    cmp("ramp", 1, v >= 20 && v <= 40);
    waitc(1000); rd(8'h84);
    cmp("duty", 32'd100, v);
    cmp("bridgeFwd", 1, bridgeFwd);
    fwdCmd <= 1'b0;
    waitc(1300); rd(8'h84);
    cmp("duty", 32'd0, v);
  endtask : t_run
  // impulse: a short pulse starts, the next one stops
  task t_impulse;
    wr(8'h00, 32'h1);
    bwdCmd <= 1'b1; waitc(5); bwdCmd <= 1'b0;
    waitc(1300);
    cmp("bridgeRev", 1, bridgeRev);
    bwdCmd <= 1'b1; waitc(5); bwdCmd <= 1'b0;
    waitc(1300); rd(8'h84);
    cmp("duty", 32'd0, v);
    wr(8'h00, 32'h0);
  endtask : t_impulse
  // outside pull stops, held command is refused after release
  task t_fault;
    fwdCmd <= 1'b1; waitc(1300);
    extPull <= 1'b1; waitc(1300); rd(8'h98);
    cmp("extFault", 32'h4, v & 32'h5);
    extPull <= 1'b0; waitc(200);
    cmp("bridgeFwd", 0, bridgeFwd);
    fwdCmd <= 1'b0; waitc(20);
  endtask : t_fault
  // overcurrent past a 1 ms delay trips and pulls the wire
  task t_trip;
    wr(8'h20, 32'h1); wr(8'h3c, 32'h5);
    loadAmps <= 8'd100; fwdCmd <= 1'b1;
    waitc(1500); rd(8'h98);
    cmp("ocTrip", 32'h8, v & 32'h8);
    cmp("faultOeN", 0, faultOeN);
    fwdCmd <= 1'b0; loadAmps <= 8'h0;
  endtask : t_trip
  // overvoltage steps: brake load first, freewheel past +10 percent
  task t_ov;
    supplyVolt <= 10'd660; waitc(5);
    cmp("brakeLoad", 1, brakeLoad);
    supplyVolt <= 10'd720; waitc(5);
    cmp("freewheel", 1, freewheel);
    supplyVolt <= 10'h1e0; waitc(5);
  endtask : t_ov
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    waitc(4);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_regs; t_run; t_impulse; t_fault; t_trip; t_ov;
    end_of_test;
  end
  initial begin
    #500_000;
    bad_count++;
    end_of_test;
  end
endmodule : dmbc_tb_top
bind dmbc_top dmbc_monitor u_mon (.sys_clk(sys_clk), .sys_rst(sys_rst), .avsAddress(avsAddress),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
  .supplyVolt(supplyVolt), .faultOut(faultOut), .bridgeFwd(bridgeFwd), .bridgeRev(bridgeRev),
  .freewheel(freewheel), .brakeLoad(brakeLoad));
`default_nettype wire
